// *** logic/vor_core.sv ***
// output overvoltage fault response and warning threshold registers with their control
`timescale 1ns/1ps
`include "vor_defs.svh"
module vor_core #(
  parameter int unsigned RETRY_CYCLES = `VOR_RETRY_CYCLES
) (
  input  wire logic                cmd_valid,
  input  wire vor_pkg::vor_cmd_s   cmd,
  output logic [15:0]              rd_data,
  output logic                     rd_valid,
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                nvm_restore,
  input  wire logic                nvm_retry_bit,
  input  wire logic [1:0]          nvm_warn_setting,
  output logic                     nvm_save_retry_bit,
  output logic [1:0]               nvm_save_warn_setting,
  input  wire logic                ov_limit_trip,
  input  wire logic                ov_fixed_trip,
  input  wire logic                ov_warn_trip,
  input  wire logic                enable_pin,
  input  wire logic                soft_start_done,
  output logic                     convert_enable,
  output logic                     limit_tracking_on,
  output vor_pkg::vor_warn_e       warn_setting,
  output vor_pkg::vor_status_s     status,
  output logic                     smbalert_o,
  output logic                     smbalert_oe
);

  // register state
  logic                  resp_en_q;
  logic [2:0]            retry_q;
  logic [10:0]           warn_q;
  vor_pkg::vor_state_e   state_q;
  vor_pkg::vor_status_s  status_q;
  logic                  pending_q;
  logic                  resp_en_prev_q;
  logic [15:0]           rd_data_q;
  logic                  rd_valid_q;
  vor_pkg::vor_warn_e    warn_set_q;

  // synchronisers for pins from the analog side
  logic [3:0]            sync1_q;
  logic [3:0]            sync2_q;
  logic                  en_prev_q;
  logic                  trip_prev_q;

  logic                  limit_trip_s;
  logic                  fixed_trip_s;
  logic                  warn_trip_s;
  logic                  en_s;
  logic                  fault_now;
  logic                  fault_rise;
  logic                  en_rise;
  logic                  clear_cmd;
  logic                  wr_act;
  logic                  wr_warn;
  logic                  act_bad;
  logic                  warn_bad;
  logic                  shutdown_req;
  logic                  retry_done;
  logic                  timer_start;
  logic                  timer_abort;
  vor_pkg::vor_warn_e    warn_decode;
  logic [10:0]           warn_restore;

  // two flops per asynchronous input
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {enable_pin, ov_warn_trip, ov_fixed_trip, ov_limit_trip};
      sync2_q <= sync1_q;
    end
  end

  assign limit_trip_s = sync2_q[0];
  assign fixed_trip_s = sync2_q[1];
  assign warn_trip_s  = sync2_q[2];
  assign en_s         = sync2_q[3];

  // limit comparator only counts once the ramp is done
  assign limit_tracking_on = soft_start_done;                                 // [R18]
  assign fault_now = (limit_trip_s && soft_start_done) || fixed_trip_s;       // [R1] [R18]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      en_prev_q   <= 1'b0;
      trip_prev_q <= 1'b0;
    end else begin
      en_prev_q   <= en_s;
      trip_prev_q <= fault_now;
    end
  end

  assign fault_rise = fault_now && !trip_prev_q;
  assign en_rise    = en_s && !en_prev_q;

  // command decode
  assign clear_cmd = cmd_valid && cmd.write && cmd.code == `VOR_CMD_CLEAR_FAULTS;
  assign wr_act    = cmd_valid && cmd.write && cmd.code == `VOR_CMD_OV_FAULT_ACT;
  assign wr_warn   = cmd_valid && cmd.write && cmd.code == `VOR_CMD_OV_WARN_THR;

  assign act_bad  = wr_act
                    && cmd.wdata[`VOR_ACT_RETRY_HI:`VOR_ACT_RETRY_LO] != `VOR_RETRY_LATCH
                    && cmd.wdata[`VOR_ACT_RETRY_HI:`VOR_ACT_RETRY_LO] != `VOR_RETRY_AUTO;   // [R7]
  assign warn_bad = wr_warn
                    && cmd.wdata[`VOR_WARN_RESV_HI:`VOR_WARN_RESV_LO] != 5'h00;             // [R17]

  // fault action byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_en_q <= 1'b1;                                                      // [R3]
      retry_q   <= `VOR_RETRY_LATCH;
    end else if (nvm_restore) begin
      resp_en_q <= 1'b1;
      retry_q   <= {3{nvm_retry_bit}};                                        // [R8]
    end else if (wr_act && !act_bad) begin                                    // [R7]
      resp_en_q <= cmd.wdata[`VOR_ACT_EN_BIT];                                // [R3]
      retry_q   <= cmd.wdata[`VOR_ACT_RETRY_HI:`VOR_ACT_RETRY_LO];
    end
  end

  assign nvm_save_retry_bit = retry_q[2];                                     // [R8]

  // warning threshold word
  always_comb begin
    if (warn_q < `VOR_WARN_EDGE_12) begin                                     // [R15]
      warn_decode = vor_pkg::VOR_WARN_8;
    end else if (warn_q < `VOR_WARN_EDGE_16) begin
      warn_decode = vor_pkg::VOR_WARN_12;
    end else if (warn_q < `VOR_WARN_EDGE_28) begin
      warn_decode = vor_pkg::VOR_WARN_16;
    end else begin
      warn_decode = vor_pkg::VOR_WARN_28;
    end
  end

  always_comb begin
    unique case (nvm_warn_setting)                                            // [R16]
      2'h0: warn_restore = `VOR_WARN_RESTORE_8;
      2'h1: warn_restore = `VOR_WARN_RESTORE_12;
      2'h2: warn_restore = `VOR_WARN_RESTORE_16;
      2'h3: warn_restore = `VOR_WARN_RESTORE_28;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warn_q <= `VOR_WARN_RESET;
    end else if (nvm_restore) begin
      warn_q <= warn_restore;                                                 // [R16]
    end else if (wr_warn && !warn_bad) begin
      warn_q <= cmd.wdata[`VOR_WARN_HI:0];                                    // [R12] [R14]
    end
  end

  // hardware setting is the highest supported one at or below the field (8% for any field under 560), not the raw field
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warn_set_q <= vor_pkg::VOR_WARN_8;
    end else begin
      warn_set_q <= warn_decode;                                              // [R14] [R15]
    end
  end

  assign warn_setting          = warn_set_q;
  assign nvm_save_warn_setting = warn_set_q;

  // register reads, answered one cycle after the request
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_q  <= 16'h0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= cmd_valid && !cmd.write;
      if (cmd_valid && !cmd.write) begin
        unique case (cmd.code)
          `VOR_CMD_OV_FAULT_ACT: begin
            rd_data_q <= {8'h00, resp_en_q, 1'b0, retry_q, retry_q};          // [R9] [R11]
          end
          `VOR_CMD_OV_WARN_THR: begin
            rd_data_q <= {5'h00, warn_q};                                     // [R11] [R12]
          end
          default: begin
            rd_data_q <= 16'h0000;
          end
        endcase
      end
    end
  end

  assign rd_data  = rd_data_q;
  assign rd_valid = rd_valid_q;

  // sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= '0;
    end else begin
      if (fault_now) begin
        status_q.byte_ovf <= 1'b1;                                            // [R2]
        status_q.word_vfw <= 1'b1;
        status_q.vout_ovf <= 1'b1;
      end else if (clear_cmd) begin
        status_q.byte_ovf <= 1'b0;                                            // [R19]
        status_q.word_vfw <= 1'b0;
        status_q.vout_ovf <= 1'b0;
      end
      if (warn_trip_s) begin
        status_q.vout_ovw <= 1'b1;                                            // [R13]
      end else if (clear_cmd) begin
        status_q.vout_ovw <= 1'b0;                                            // [R19]
      end
      if (act_bad || warn_bad) begin
        status_q.cml_ivd <= 1'b1;                                             // [R7] [R17]
      end else if (clear_cmd) begin
        status_q.cml_ivd <= 1'b0;
      end
    end
  end

  assign status = status_q;

  // alert is open drain: pulled low while any flag stands
  assign smbalert_o  = 1'b0;
  assign smbalert_oe = |status_q;                                             // [R2] [R17]

  // fault seen while ignored and not yet cleared
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_q <= 1'b0;
    end else if (fault_rise && !resp_en_q) begin
      pending_q <= 1'b1;                                                      // [R4]
    end else if (clear_cmd || resp_en_q) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp_en_prev_q <= 1'b1;
    end else begin
      resp_en_prev_q <= resp_en_q;
    end
  end

  assign shutdown_req = resp_en_q
                        && (fault_rise || (pending_q && !resp_en_prev_q));   // [R3] [R4]

  // shutdown and restart control
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= vor_pkg::VOR_RUN;
    end else begin
      unique case (state_q)
        vor_pkg::VOR_RUN: begin
          if (shutdown_req) begin
            if (retry_q == `VOR_RETRY_AUTO) begin
              state_q <= vor_pkg::VOR_WAIT;                                   // [R6] [R10]
            end else begin
              state_q <= vor_pkg::VOR_HOLD;                                   // [R5] [R10]
            end
          end
        end
        vor_pkg::VOR_HOLD: begin
          if (en_rise) begin
            state_q <= vor_pkg::VOR_RUN;                                      // [R5]
          end
        end
        vor_pkg::VOR_WAIT: begin
          if (en_rise || retry_done) begin
            state_q <= vor_pkg::VOR_RUN;                                      // [R6]
          end
        end
        default: begin
          state_q <= vor_pkg::VOR_RUN;
        end
      endcase
    end
  end

  assign timer_start = (state_q == vor_pkg::VOR_RUN) && shutdown_req
                       && (retry_q == `VOR_RETRY_AUTO);                        // [R10]
  assign timer_abort = (state_q != vor_pkg::VOR_WAIT) && !timer_start;

  vor_retry_timer #(
    .CYCLES (RETRY_CYCLES)
  ) u_retry_timer (
    .clk   (clk),
    .rst   (rst),
    .start (timer_start),
    .abort (timer_abort),
    .done  (retry_done)
  );

  // the power stage runs only in the run state with the enable pin high
  assign convert_enable = (state_q == vor_pkg::VOR_RUN) && en_s;             // [R3]

endmodule // vor_core

// *** logic/vor_defs.svh ***
// constants for the output overvoltage response and warning block
// Operation
// [R1] any overvoltage fault, programmed limit or fixed level, takes the programmed action
// [R2] a fault sets byte, word and vout fault status bits and asserts the alert line
// [R3] response-enable bit 7 resets to 1; 0 ignores the fault, 1 shuts down
// [R4] enabling the response later acts on an uncleared earlier fault
// [R5] retry field 000b latches off until power cycle or enable toggle
// [R6] retry field 111b restarts after 52ms, with no limit on attempts
// [R7] retry field values other than 000b or 111b are rejected as invalid data
// [R8] only bit 5 of the retry field is kept in storage and replicated on restore
// [R9] retry delay bits 2:0 are read-only and mirror the retry field
// [R10] delay 000b means no restart; 111b means 52ms wait before startup
// [R11] bit 6 of the response byte and bits 15:11 of the warning word read zero
// [R12] warning limit is a word register with an 11-bit field in bits 10:0
// [R13] sensed output above the warning threshold sets the vout warning bit
// [R14] warning field reads back as written; hardware uses the nearest setting at or below the field
// [R15] field below 560 gives 8%, below 584 12%, below 624 16%, else 28%
// [R16] restore loads one fixed field value per supported warning setting
// [R17] invalid warning writes are flagged as invalid data and notify the host
// [R18] limit-relative fault tracking starts only after soft-start completes
// [R19] fault and warning status bits stay set until cleared by clear faults
`ifndef VOR_DEFS_SVH
`define VOR_DEFS_SVH

`define VOR_CMD_CLEAR_FAULTS   8'h03
`define VOR_CMD_OV_FAULT_ACT   8'h41
`define VOR_CMD_OV_WARN_THR    8'h42

`define VOR_ACT_EN_BIT         7
`define VOR_ACT_ZERO_BIT       6
`define VOR_ACT_RETRY_HI       5
`define VOR_ACT_RETRY_LO       3
`define VOR_ACT_DELAY_HI       2
`define VOR_ACT_DELAY_LO       0
`define VOR_RETRY_LATCH        3'h0
`define VOR_RETRY_AUTO         3'h7
`define VOR_ACT_RESET          8'h80

`define VOR_WARN_HI            10
`define VOR_WARN_RESV_HI       15
`define VOR_WARN_RESV_LO       11
`define VOR_WARN_RESET         11'h000
`define VOR_WARN_EDGE_12       11'h230
`define VOR_WARN_EDGE_16       11'h248
`define VOR_WARN_EDGE_28       11'h270
`define VOR_WARN_RESTORE_8     11'h218
`define VOR_WARN_RESTORE_12    11'h230
`define VOR_WARN_RESTORE_16    11'h248
`define VOR_WARN_RESTORE_28    11'h270

`define VOR_CLK_HZ             25000000
`define VOR_RETRY_MS           52
`define VOR_RETRY_CYCLES       ((`VOR_CLK_HZ / 1000) * `VOR_RETRY_MS)

`endif

// *** logic/vor_pkg.sv ***
// types shared by the overvoltage response and warning block
package vor_pkg;

  typedef enum logic [2:0] {
    VOR_RUN  = 3'b001,
    VOR_HOLD = 3'b010,
    VOR_WAIT = 3'b100
  } vor_state_e;

  typedef enum logic [1:0] {
    VOR_WARN_8  = 2'h0,
    VOR_WARN_12 = 2'h1,
    VOR_WARN_16 = 2'h2,
    VOR_WARN_28 = 2'h3
  } vor_warn_e;

  typedef struct packed {
    logic [7:0]  code;
    logic        write;
    logic [15:0] wdata;
  } vor_cmd_s;

  typedef struct packed {
    logic       byte_ovf;
    logic       word_vfw;
    logic       vout_ovf;
    logic       vout_ovw;
    logic       cml_ivd;
  } vor_status_s;

endpackage

// *** logic/vor_retry_timer.sv ***
// retry delay counter: counts a fixed number of cycles after start
`timescale 1ns/1ps
module vor_retry_timer #(
  parameter int unsigned CYCLES = 1300000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      done
);
  localparam int W = $clog2(CYCLES + 1);

  logic [W-1:0] cnt_q;
  logic         run_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (abort) begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end else if (start) begin
      cnt_q <= W'(CYCLES - 1);
      run_q <= 1'b1;
    end else if (run_q && cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end else begin
      run_q <= 1'b0;
    end
  end

  assign done = run_q && (cnt_q == '0) && !abort;

endmodule // vor_retry_timer

// *** tb/vor_core_props.sv ***
// assertions on the ports of the overvoltage response and warning block
`timescale 1ns/1ps
module vor_core_props #(
  parameter int unsigned RETRY_CYCLES = 20
) (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 cmd_valid,
  input wire vor_pkg::vor_cmd_s    cmd,
  input wire logic [15:0]          rd_data,
  input wire logic                 rd_valid,
  input wire logic                 nvm_restore,
  input wire logic                 soft_start_done,
  input wire logic                 limit_tracking_on,
  input wire vor_pkg::vor_status_s status,
  input wire logic                 smbalert_o,
  input wire logic                 smbalert_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rdc = cmd_valid && !cmd.write;
  wire logic wrc = cmd_valid && cmd.write && !nvm_restore;
  wire logic clr = cmd_valid && cmd.write && cmd.code == 8'h03;
  a_read_answer: assert property (rdc |=> rd_valid) else $error("read not answered");
  a_no_extra: assert property (!rdc |=> !rd_valid) else $error("spurious read answer");
  a_act_layout: assert property (rdc && cmd.code == 8'h41 |=> rd_data[15:8] == 8'h00 && !rd_data[6]
    && rd_data[2:0] == rd_data[5:3]) else $error("action readback layout wrong");
  a_retry_legal: assert property (rdc && cmd.code == 8'h41 |=> rd_data[5:3] == 3'h0 || rd_data[5:3] == 3'h7)
    else $error("illegal retry value held");
  a_warn_resv: assert property (rdc && cmd.code == 8'h42 |=> rd_data[15:11] == 5'h00)
    else $error("warning reserved bits set");
  a_bad_retry: assert property (wrc && cmd.code == 8'h41 && cmd.wdata[5:3] != 3'h0 && cmd.wdata[5:3] != 3'h7
    |=> status.cml_ivd) else $error("bad retry write not flagged");
  a_bad_warn: assert property (wrc && cmd.code == 8'h42 && |cmd.wdata[15:11] |=> status.cml_ivd)
    else $error("bad warning write not flagged");
  a_fault_bits: assert property ($rose(status.vout_ovf) |-> status.byte_ovf && status.word_vfw)
    else $error("fault status bits not set together");
  a_alert_set: assert property (status.vout_ovf |-> smbalert_oe && !smbalert_o)
    else $error("alert not driven on fault");
  a_fault_sticky: assert property (status.vout_ovf && !clr |=> status.vout_ovf)
    else $error("fault status dropped without clear");
  a_track_ss: assert property (limit_tracking_on == soft_start_done)
    else $error("tracking enable differs from soft start");
  cover property (rdc && cmd.code == 8'h41);
  cover property ($rose(status.vout_ovf));
  cover property ($rose(status.cml_ivd));
endmodule // vor_core_props
bind vor_core vor_core_props #(.RETRY_CYCLES(RETRY_CYCLES)) u_props (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
  .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid), .nvm_restore(nvm_restore), .soft_start_done(soft_start_done),
  .limit_tracking_on(limit_tracking_on), .status(status), .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe));

// *** tb/vor_host.sv ***
// host model issuing commands on the command port
`timescale 1ns/1ps
module vor_host (
  input  wire logic         clk,
  output logic              cmd_valid,
  output vor_pkg::vor_cmd_s cmd,
  input  wire logic [15:0]  rd_data,
  input  wire logic         rd_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // one-cycle strobe at the falling edge; the answer stands for the cycle after the taking edge
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d, output logic [15:0] r,
                      output logic ok);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{c, w, d};
    @(negedge clk);
    ok = rd_valid;
    r = rd_data;
    cmd_valid = 1'b0;
    cmd.wdata = ~d;
  endtask
endmodule // vor_host

// *** tb/tb.sv ***
// testbench for the overvoltage response and warning block
`timescale 1ns/1ps
module tb;
  localparam int unsigned RC = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid, rd_valid, nvm_restore, nvm_retry_bit, nvm_save_retry_bit, convert_enable;
  logic ov_limit_trip, ov_fixed_trip, ov_warn_trip, enable_pin, soft_start_done, limit_tracking_on;
  logic smbalert_o, smbalert_oe;
  logic [1:0] nvm_warn_setting, nvm_save_warn_setting;
  logic [15:0] rd_data;
  vor_pkg::vor_cmd_s cmd;
  vor_pkg::vor_warn_e warn_setting;
  vor_pkg::vor_status_s status;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [15:0] wv [8] = '{16'h0000, 16'h022F, 16'h0230, 16'h0247, 16'h0248, 16'h026F, 16'h0270, 16'h07FF};
  logic [1:0] ws [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [15:0] rv [4] = '{16'h0218, 16'h0230, 16'h0248, 16'h0270};
  always #20 clk = ~clk;
  vor_core #(.RETRY_CYCLES(RC)) DUT (.cmd_valid(cmd_valid), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid),
    .clk(clk), .rst(rst), .nvm_restore(nvm_restore), .nvm_retry_bit(nvm_retry_bit),
    .nvm_warn_setting(nvm_warn_setting), .nvm_save_retry_bit(nvm_save_retry_bit),
    .nvm_save_warn_setting(nvm_save_warn_setting), .ov_limit_trip(ov_limit_trip), .ov_fixed_trip(ov_fixed_trip),
    .ov_warn_trip(ov_warn_trip), .enable_pin(enable_pin), .soft_start_done(soft_start_done),
    .convert_enable(convert_enable), .limit_tracking_on(limit_tracking_on), .warn_setting(warn_setting),
    .status(status), .smbalert_o(smbalert_o), .smbalert_oe(smbalert_oe));
  vor_host u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd(cmd), .rd_data(rd_data), .rd_valid(rd_valid));
  task automatic stop_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] r;
    logic ok;
    u_host.xfer(c, 1'b0, 16'h0000, r, ok);
    chk({15'h0000, ok}, 16'h0001);
    chk(r, e);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    logic [15:0] r;
    logic ok;
    u_host.xfer(c, 1'b1, d, r, ok);
  endtask
  task automatic st(input logic [4:0] e);
    chk({11'h000, status}, {11'h000, e});
    chk({15'h0000, smbalert_oe}, {15'h0000, |e});
  endtask
  task automatic ce(input logic e);
    chk({15'h0000, convert_enable}, {15'h0000, e});
  endtask
  task automatic clr();
    wr(8'h03, 16'h0000);
    cyc(2);
  endtask
  task automatic trip(ref logic p);
    p = 1'b1;
    cyc(3);
    p = 1'b0;
    cyc(3);
  endtask
  task automatic wait_ce(input logic v);
    n = 0;
    while (convert_enable !== v && n < 200) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic s_reset();
    rd(8'h41, 16'h0080);
    rd(8'h42, 16'h0000);
    st(5'h00);
    ce(1'b1);
  endtask
  task automatic s_restore();
    for (int i = 0; i < 4; i++) begin
      nvm_retry_bit = i[0];
      nvm_warn_setting = i[1:0];
      nvm_restore = 1'b1;
      cyc(1);
      nvm_restore = 1'b0;
      cyc(2);
      rd(8'h42, rv[i]);
      rd(8'h41, i[0] ? 16'h00BF : 16'h0080);
      chk({15'h0000, nvm_save_retry_bit}, {15'h0000, i[0]});
      chk({14'h0000, nvm_save_warn_setting}, {14'h0000, i[1:0]});
      chk({14'h0000, warn_setting}, {14'h0000, i[1:0]});
    end
  endtask
  task automatic s_action();
    wr(8'h41, 16'h0047);
    rd(8'h41, 16'h0000);
    wr(8'h41, 16'h00FF);
    rd(8'h41, 16'h00BF);
    wr(8'h41, 16'h0090);
    rd(8'h41, 16'h00BF);
    st(5'h01);
    clr();
  endtask
  task automatic s_warn();
    for (int i = 0; i < 8; i++) begin
      wr(8'h42, wv[i]);
      rd(8'h42, wv[i]);
      chk({14'h0000, warn_setting}, {14'h0000, ws[i]});
    end
    wr(8'h42, 16'h0A30);
    rd(8'h42, 16'h07FF);
    st(5'h01);
    clr();
    st(5'h00);
  endtask
  task automatic s_latch();
    wr(8'h41, 16'h0080);
    trip(ov_fixed_trip);
    st(5'h1C);
    ce(1'b0);
    cyc(40);
    ce(1'b0);
    enable_pin = 1'b0;
    cyc(4);
    enable_pin = 1'b1;
    wait_ce(1'b1);
    ce(1'b1);
    clr();
    st(5'h00);
  endtask
  task automatic s_retry();
    wr(8'h41, 16'h00BF);
    for (int k = 0; k < 2; k++) begin
      trip(ov_limit_trip);
      ce(1'b0);
      wait_ce(1'b1);
      chk({15'h0000, n >= RC - 6 && n <= RC + 4}, 16'h0001);
    end
    clr();
  endtask
  task automatic s_soft_start();
    soft_start_done = 1'b0;
    cyc(1);
    chk({15'h0000, limit_tracking_on}, 16'h0000);
    trip(ov_limit_trip);
    st(5'h00);
    ce(1'b1);
    soft_start_done = 1'b1;
  endtask
  task automatic s_ignore();
    wr(8'h41, 16'h003F);
    trip(ov_fixed_trip);
    st(5'h1C);
    ce(1'b1);
    wr(8'h41, 16'h00BF);
    cyc(2);
    ce(1'b0);
    wait_ce(1'b1);
    ce(1'b1);
    clr();
  endtask
  task automatic s_warn_status();
    ov_warn_trip = 1'b1;
    cyc(4);
    st(5'h02);
    ov_warn_trip = 1'b0;
    cyc(4);
    st(5'h02);
    clr();
    st(5'h00);
  endtask
  initial begin
    {nvm_restore, nvm_retry_bit, nvm_warn_setting, ov_limit_trip, ov_fixed_trip, ov_warn_trip} = '0;
    enable_pin = 1'b1;
    soft_start_done = 1'b1;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    cyc(4);
    s_reset();
    s_restore();
    s_action();
    s_warn();
    s_latch();
    s_retry();
    s_soft_start();
    s_ignore();
    s_warn_status();
    stop_test();
  end
endmodule // tb
